// ===== design/iosec_pkg.sv
// constants and carrier types of the i/o stack event counter select block
package iosec_pkg;
   // counter bank shape
   localparam int NCNT = 4;
   localparam int CNT_W = 32;
   localparam int DWORD_MAX_CNT = 2;
   // register byte offsets
   localparam logic [7:0] OFS_CTL = 8'h00;
   localparam logic [7:0] OFS_FILT = 8'h04;
   localparam logic [7:0] OFS_CNT = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h40;
   localparam logic [7:0] OFS_MASK = 8'h44;
   localparam logic [7:0] BANK_END = 8'h40;
   // control register fields
   localparam int CTL_CODE_LSB = 0;
   localparam int CTL_UMASK_LSB = 8;
   localparam int CTL_EN_BIT = 22;
   localparam int FILT_W = 11;
   localparam logic [2:0] FILT_TAG = 3'h7;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // event codes
   localparam logic [7:0] EV_NULL = 8'h00;
   localparam logic [7:0] EV_DBG_AND = 8'h02;
   localparam logic [7:0] EV_DBG_OR = 8'h03;
   localparam logic [7:0] EV_RETRY = 8'h0e;
   localparam logic [7:0] EV_CORR = 8'h0f;
   localparam logic [7:0] EV_MM = 8'h21;
   localparam logic [7:0] EV_SYM = 8'h82;
   localparam logic [7:0] EV_DWORD = 8'h83;
   // transaction classes whose peer traffic can stay inside the stack
   localparam logic [7:0] CLS_PEER = 8'h0a;
   // link speed codes and symbol times
   localparam logic [1:0] SPD_GEN1 = 2'h0;
   localparam logic [1:0] SPD_GEN2 = 2'h1;
   localparam logic [1:0] SPD_GEN3 = 2'h2;
   localparam int CLK_NS = 4;
   localparam int SYM_GEN1_NS = 4;
   localparam int SYM_GEN2_NS = 2;
   localparam int SYM_GEN3_NS = 1;
   localparam logic [2:0] SYM_INC_GEN1 = 3'(CLK_NS / SYM_GEN1_NS);
   localparam logic [2:0] SYM_INC_GEN2 = 3'(CLK_NS / SYM_GEN2_NS);
   localparam logic [2:0] SYM_INC_GEN3 = 3'(CLK_NS / SYM_GEN3_NS);
   // per-counter selection
   typedef struct packed {
      logic en;
      logic [7:0] umask;
      logic [7:0] code;
   } iosec_cfg_t;
   // one request on the request path
   typedef struct packed {
      logic valid;
      logic confined;
      logic [7:0] cls;
      logic [3:0] part;
      logic [1:0] xlat;
   } iosec_req_t;
endpackage

// ===== design/iosec_top.sv
// event selection, filtering and counting for one i/o stack monitor
//
// Notes on behaviour
// - code 0x83 counts each dword request, on counters 0 and 1 only
// - dword event counts requests, not completions
// - peer classes skip stack-confined peer traffic
// - umask one-hot picks transaction class
// - filter needs 111 tag plus one-hot selector
// - partition bits map card slots/lanes
// - 0x0f correctable errors, 0x0e link retries
// - 0x21 counts mask/match filter passes
// - 0x02 fires when all selected terms match
// - 0x03 fires when any selected term matches
// - umask picks bus terms and combinations
// - symbol time adds 1/2/4 per cycle
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iosec_top (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   // stack events, same clock
   input wire iosec_pkg::iosec_req_t REQ,
   input wire logic LINK_CORR_ERR,
   input wire logic LINK_RETRY,
   input wire logic MM_PASS,
   input wire logic DBG_NON_PCIE_BUS_MATCH_MATCH,
   input wire logic DBG_PCIE_BUS_MATCH_MATCH,
   input wire logic [1:0] LINK_SPEED,
   // interrupt
   output logic IRQ
);
   // ****************************************
   // functions
   // ****************************************
   // filter tag plus one-hot partition / translation selector
   function automatic logic filt_ok(input logic [10:0] f, input iosec_pkg::iosec_req_t r);
      logic [5:0] sel;
      sel = {r.xlat, r.part};
      filt_ok = (f[10:8] == iosec_pkg::FILT_TAG) && (|(f[5:0] & sel));
   endfunction

   // debug bus terms in umask bit order
   function automatic logic [5:0] dbg_terms(input logic b0, input logic b1);
      dbg_terms = {~b0 & ~b1, ~b0 & b1, b0 & b1, b0 & ~b1, b1, b0};
   endfunction

   // map a byte address to a counter slot
   function automatic logic [1:0] slot_of(input logic [7:0] a);
      slot_of = a[5:4];
   endfunction

   // ****************************************
   // bus slave
   // ****************************************
   iosec_pkg::iosec_cfg_t cfg_reg [iosec_pkg::NCNT];
   logic [10:0] filt_reg [iosec_pkg::NCNT];
   logic [31:0] cnt_reg [iosec_pkg::NCNT];
   logic [iosec_pkg::NCNT-1:0] stat_reg;
   logic [iosec_pkg::NCNT-1:0] mask_reg;
   logic [iosec_pkg::NCNT-1:0] ovf_next;
   logic irq_reg;
   logic hready_reg;
   logic [31:0] hrdata_reg;
   logic dp_valid_reg;
   logic dp_wr_reg;
   logic dp_word_reg;
   logic [7:0] dp_addr_reg;
   logic ap_take;
   logic wr_go;
   logic [31:0] rd_mux;
   logic [1:0] wslot;
   logic wbank;

   assign ap_take = HSEL & HREADY & HTRANS[1];
   assign wr_go = dp_valid_reg & dp_wr_reg & dp_word_reg;
   assign wslot = slot_of(dp_addr_reg);
   assign wbank = dp_addr_reg < iosec_pkg::BANK_END;

   // address phase capture; reads take one wait state, writes none
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         dp_valid_reg <= 1'b0;
         dp_wr_reg <= 1'b0;
         dp_word_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         hready_reg <= 1'b1;
         hrdata_reg <= iosec_pkg::REG_RST;
      end else begin
         if (dp_valid_reg & ~dp_wr_reg) begin
            hrdata_reg <= rd_mux;
            hready_reg <= 1'b1;
         end
         if (ap_take) begin
            dp_valid_reg <= 1'b1;
            dp_wr_reg <= HWRITE;
            dp_word_reg <= HSIZE == 3'h2;
            dp_addr_reg <= {HADDR[7:2], 2'h0};
            hready_reg <= HWRITE;
         end else begin
            dp_valid_reg <= 1'b0;
         end
      end
   end

   // read multiplexer, unmapped reads as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (dp_addr_reg < iosec_pkg::BANK_END) begin
         unique case (dp_addr_reg[3:0])
            iosec_pkg::OFS_CTL[3:0]: begin
               rd_mux[iosec_pkg::CTL_EN_BIT] = cfg_reg[slot_of(dp_addr_reg)].en;
               rd_mux[15:8] = cfg_reg[slot_of(dp_addr_reg)].umask;
               rd_mux[7:0] = cfg_reg[slot_of(dp_addr_reg)].code;
            end
            iosec_pkg::OFS_FILT[3:0]: rd_mux[10:0] = filt_reg[slot_of(dp_addr_reg)];
            iosec_pkg::OFS_CNT[3:0]: rd_mux = cnt_reg[slot_of(dp_addr_reg)];
            default: rd_mux = 32'h0000_0000;
         endcase
      end else if (dp_addr_reg == iosec_pkg::OFS_STAT) begin
         rd_mux[iosec_pkg::NCNT-1:0] = stat_reg;
      end else if (dp_addr_reg == iosec_pkg::OFS_MASK) begin
         rd_mux[iosec_pkg::NCNT-1:0] = mask_reg;
      end
   end

   // ****************************************
   // event selection
   // ****************************************
   logic [7:0] cls_eff;
   logic [5:0] terms;
   logic [2:0] sym_inc;
   logic [2:0] inc [iosec_pkg::NCNT];

   // confined peer traffic never reaches the main die
   assign cls_eff = REQ.confined ? (REQ.cls & ~iosec_pkg::CLS_PEER) : REQ.cls;
   assign terms = dbg_terms(DBG_NON_PCIE_BUS_MATCH_MATCH, DBG_PCIE_BUS_MATCH_MATCH);

   // symbol time weight for the current link speed
   always_comb begin
      unique case (LINK_SPEED)
         iosec_pkg::SPD_GEN1: sym_inc = iosec_pkg::SYM_INC_GEN1;
         iosec_pkg::SPD_GEN2: sym_inc = iosec_pkg::SYM_INC_GEN2;
         iosec_pkg::SPD_GEN3: sym_inc = iosec_pkg::SYM_INC_GEN3;
         default: sym_inc = 3'h0;
      endcase
   end

   // per-counter increment from its event code and unit mask
   always_comb begin
      for (int i = 0; i < iosec_pkg::NCNT; i++) begin
         inc[i] = 3'h0;
         unique case (cfg_reg[i].code)
            iosec_pkg::EV_NULL: inc[i] = 3'h0;
            iosec_pkg::EV_DWORD: begin
               // request path only; dword event limited to low counters
               if (i < iosec_pkg::DWORD_MAX_CNT && REQ.valid) begin
                  inc[i] = {2'h0, (|(cfg_reg[i].umask & cls_eff)) & filt_ok(filt_reg[i], REQ)};
               end
            end
            iosec_pkg::EV_CORR: inc[i] = {2'h0, LINK_CORR_ERR};
            iosec_pkg::EV_RETRY: inc[i] = {2'h0, LINK_RETRY};
            iosec_pkg::EV_MM: inc[i] = {2'h0, MM_PASS};
            iosec_pkg::EV_DBG_AND: inc[i] = {2'h0, (|cfg_reg[i].umask[5:0])
               && ((terms & cfg_reg[i].umask[5:0]) == cfg_reg[i].umask[5:0])};
            iosec_pkg::EV_DBG_OR: inc[i] = {2'h0, |(terms & cfg_reg[i].umask[5:0])};
            iosec_pkg::EV_SYM: inc[i] = sym_inc;
            default: inc[i] = 3'h0;
         endcase
         if (!cfg_reg[i].en) begin
            inc[i] = 3'h0;
         end
      end
   end

   // ****************************************
   // registers and counters
   // ****************************************
   // control and filter registers
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         for (int i = 0; i < iosec_pkg::NCNT; i++) begin
            cfg_reg[i] <= '0;
            filt_reg[i] <= 11'h000;
         end
         mask_reg <= '0;
      end else if (wr_go) begin
         if (wbank && dp_addr_reg[3:0] == iosec_pkg::OFS_CTL[3:0]) begin
            cfg_reg[wslot].en <= HWDATA[iosec_pkg::CTL_EN_BIT];
            cfg_reg[wslot].umask <= HWDATA[15:8];
            cfg_reg[wslot].code <= HWDATA[7:0];
         end
         if (wbank && dp_addr_reg[3:0] == iosec_pkg::OFS_FILT[3:0]) begin
            filt_reg[wslot] <= HWDATA[10:0];
         end
         if (dp_addr_reg == iosec_pkg::OFS_MASK) begin
            mask_reg <= HWDATA[iosec_pkg::NCNT-1:0];
         end
      end
   end

   // counters; a software load wins over counting in that cycle
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         for (int i = 0; i < iosec_pkg::NCNT; i++) begin
            cnt_reg[i] <= iosec_pkg::REG_RST;
         end
      end else begin
         for (int i = 0; i < iosec_pkg::NCNT; i++) begin
            if (wr_go && wbank && wslot == 2'(i) && dp_addr_reg[3:0] == iosec_pkg::OFS_CNT[3:0]) begin
               cnt_reg[i] <= HWDATA;
            end else begin
               cnt_reg[i] <= cnt_reg[i] + {29'h0000_0000, inc[i]};
            end
         end
      end
   end

   // wrap of a counting counter is an interrupt event
   always_comb begin
      for (int i = 0; i < iosec_pkg::NCNT; i++) begin
         // a software load in the same cycle drops the event, so it cannot wrap either
         ovf_next[i] = (({1'b0, cnt_reg[i]} + {30'h0000_0000, inc[i]}) > 33'h0_FFFF_FFFF)
            && !(wr_go && wbank && wslot == 2'(i) && dp_addr_reg[3:0] == iosec_pkg::OFS_CNT[3:0]);
      end
   end

   // sticky status, write one to clear, a new event wins
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         stat_reg <= '0;
      end else if (wr_go && dp_addr_reg == iosec_pkg::OFS_STAT) begin
         stat_reg <= (stat_reg & ~HWDATA[iosec_pkg::NCNT-1:0]) | ovf_next;
      end else begin
         stat_reg <= stat_reg | ovf_next;
      end
   end

   // interrupt level
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(stat_reg & mask_reg);
      end
   end

   assign HREADYOUT = hready_reg;
   assign HRDATA = hrdata_reg;
   assign HRESP = 1'b0; // always okay
   assign IRQ = irq_reg;

   // ****************************************
   // assertions on counter 0
   // ****************************************
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   logic c0_run;
   logic [7:0] c0_code;
   assign c0_run = cfg_reg[0].en && !(wr_go && dp_addr_reg == iosec_pkg::OFS_CNT);
   assign c0_code = cfg_reg[0].code;

   AST_NULL_HOLDS: assert property (c0_run && c0_code == 8'h00 |=> $stable(cnt_reg[0]))
      else $error("null event moved counter");
   AST_CORR_COUNTS: assert property (c0_run && c0_code == 8'h0f && LINK_CORR_ERR
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001) else $error("corr error not counted");
   AST_RETRY_COUNTS: assert property (c0_run && c0_code == 8'h0e && !LINK_RETRY
      |=> $stable(cnt_reg[0])) else $error("retry counted without retry");
   AST_MM_COUNTS: assert property (c0_run && c0_code == 8'h21 && MM_PASS
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001) else $error("filter pass not counted");
   AST_DWORD_REQ: assert property (c0_run && c0_code == 8'h83 && cfg_reg[0].umask == 8'h01
      && filt_reg[0] == 11'h701 && REQ.valid && REQ.cls == 8'h01 && REQ.part == 4'h1
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001) else $error("dword request lost");
   AST_READ_AT_REQUEST: assert property (c0_run && c0_code == 8'h83 && !REQ.valid
      |=> $stable(cnt_reg[0])) else $error("counted without request");
   AST_CONFINED_PEER: assert property (c0_run && c0_code == 8'h83 && cfg_reg[0].umask == 8'h02
      && REQ.cls == 8'h02 && REQ.confined |=> $stable(cnt_reg[0])) else $error("confined peer counted");
   AST_CLASS_SELECT: assert property (c0_run && c0_code == 8'h83 && cfg_reg[0].umask == 8'h04
      && REQ.cls == 8'h01 |=> $stable(cnt_reg[0])) else $error("wrong class counted");
   AST_FILTER_TAG: assert property (c0_run && c0_code == 8'h83 && filt_reg[0][10:8] != 3'h7
      |=> $stable(cnt_reg[0])) else $error("untagged filter counted");
   AST_PART_TWO: assert property (c0_run && c0_code == 8'h83 && filt_reg[0] == 11'h704
      && REQ.part == 4'h1 && REQ.xlat == 2'h0 |=> $stable(cnt_reg[0])) else $error("partition leak");
   AST_DBG_AND: assert property (c0_run && c0_code == 8'h02 && cfg_reg[0].umask == 8'h03
      && DBG_NON_PCIE_BUS_MATCH_MATCH && !DBG_PCIE_BUS_MATCH_MATCH |=> $stable(cnt_reg[0])) else $error("and fired on partial");
   AST_DBG_OR: assert property (c0_run && c0_code == 8'h03 && cfg_reg[0].umask == 8'h03
      && DBG_NON_PCIE_BUS_MATCH_MATCH && !DBG_PCIE_BUS_MATCH_MATCH |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001)
      else $error("or missed a match");
   AST_DBG_NEITHER: assert property (c0_run && c0_code == 8'h03 && cfg_reg[0].umask == 8'h20
      && !DBG_NON_PCIE_BUS_MATCH_MATCH && !DBG_PCIE_BUS_MATCH_MATCH |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0001)
      else $error("neither term missed");
   AST_SYM_GEN2: assert property (c0_run && c0_code == 8'h82 && LINK_SPEED == 2'h1
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h0000_0002) else $error("gen2 symbol step wrong");

   COV_DWORD: cover property (c0_run && c0_code == 8'h83 && REQ.valid ##1 $changed(cnt_reg[0]));
   COV_IRQ: cover property ($rose(IRQ));
   COV_READ: cover property (!HREADYOUT ##1 HREADYOUT);
endmodule
`default_nettype wire

// ===== dv/iosec_stack_model.sv
// partner model: cards, link and debug bus that feed the stack events
`timescale 1ns/1ps
`default_nettype none
module iosec_stack_model (
   // clock
   input wire logic clk,
   // request path and link events
   output var iosec_pkg::iosec_req_t req,
   output logic corr_err,
   output logic retry,
   output logic mm_pass,
   // debug bus levels and link speed
   output logic non_pcie_bus_match_match,
   output logic pcie_bus_match_match,
   output logic [1:0] link_speed
);
   // quiet state at time zero, no speed reported
   initial begin
      req = '0;
      corr_err = 1'b0;
      retry = 1'b0;
      mm_pass = 1'b0;
      non_pcie_bus_match_match = 1'b0;
      pcie_bus_match_match = 1'b0;
      link_speed = 2'h3;
   end
   // debug levels seen while no burst runs
   task automatic prep(input logic [15:0] arg);
      {pcie_bus_match_match, non_pcie_bus_match_match} <= arg[3:2];
   endtask
   // n cycles of one kind of activity, then release
   task automatic burst(input int kind, input int n, input logic [15:0] arg);
      for (int i = 0; i < n; i++) begin
         case (kind)
            0: req <= {1'b1, arg[14:0]};
            1: corr_err <= 1'b1;
            2: retry <= 1'b1;
            3: mm_pass <= 1'b1;
            4: {pcie_bus_match_match, non_pcie_bus_match_match} <= arg[1:0];
            default: link_speed <= arg[1:0];
         endcase
         @(posedge clk);
      end
      // released request fields flip so stale values never look valid
      req <= {1'b0, ~req[14:0]};
      corr_err <= 1'b0;
      retry <= 1'b0;
      mm_pass <= 1'b0;
      {pcie_bus_match_match, non_pcie_bus_match_match} <= arg[3:2];
      link_speed <= 2'h3;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_iosec_top.sv
// testbench for the i/o stack event counter select block
`timescale 1ns/1ps
`default_nettype none
module tb_iosec_top;
   logic SYS_CLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   iosec_pkg::iosec_req_t req;
   logic corr, rtry, mm, b0, b1;
   logic [1:0] spd;
   logic [31:0] q;
   int mismatches = 0;
   int n_tests = 0;
   logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h40, 8'h44};

   iosec_top dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HREADYOUT(HREADYOUT),
      .HRDATA(HRDATA), .HRESP(HRESP), .REQ(req), .LINK_CORR_ERR(corr), .LINK_RETRY(rtry),
      .MM_PASS(mm), .DBG_NON_PCIE_BUS_MATCH_MATCH(b0), .DBG_PCIE_BUS_MATCH_MATCH(b1), .LINK_SPEED(spd), .IRQ(IRQ));
   iosec_stack_model st (.clk(SYS_CLK), .req(req), .corr_err(corr), .retry(rtry), .mm_pass(mm),
      .non_pcie_bus_match_match(b0), .pcie_bus_match_match(b1), .link_speed(spd));

   // clock at 250 MHz
   initial begin
      SYS_CLK = 1'b0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: value %h expected %h", $time, seen, exp);
      end
   endtask
   // ****************************************
   // bus master and event runs
   // ****************************************
   // waits for an edge that samples ready high, bounded
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge SYS_CLK);
         k++;
      end while (HREADYOUT !== 1'b1 && k < 20);
      if (k >= 20) begin
         mismatches++;
         $display("Error at %0t: bus wait ran out", $time);
         finish_test();
      end
   endtask
   // one single word transfer; read data taken at the closing edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
      HSEL <= 1'b1;
      HADDR <= {24'h00_0000, a};
      HTRANS <= 2'b10;
      HWRITE <= wr;
      wait_rdy();
      HTRANS <= 2'b00;
      HWDATA <= d;
      wait_rdy();
      rd = HRDATA;
   endtask
   function automatic logic [15:0] rq(logic cf, logic [7:0] cls, logic [3:0] p, logic [1:0] x);
      return {1'b0, cf, cls, p, x};
   endfunction
   // clear, select, run a burst, stop, read the count and compare
   task automatic run(input int c, input logic [7:0] code, input logic [7:0] um, input logic [31:0] f,
         input int kind, input int n, input logic [15:0] arg, input logic [31:0] exp);
      logic [7:0] b;
      logic [31:0] rd;
      b = 8'(16 * c);
      st.prep(arg);
      bus(1'b1, b + 8'h08, 32'h0000_0000, rd);
      bus(1'b1, b + 8'h04, f, rd);
      bus(1'b1, b, {9'h000, 1'b1, 6'h00, um, code}, rd);
      st.burst(kind, n, arg);
      bus(1'b1, b, 32'h0000_0000, rd);
      bus(1'b0, b + 8'h08, 32'h0000_0000, rd);
      chk(rd, exp);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      RESETN = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h0000_0000;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0000_0000;
      repeat (2) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      @(posedge SYS_CLK);
      // reset values, field width, unmapped place
      foreach (ra[i]) begin
         bus(1'b0, ra[i], 32'h0000_0000, q);
         chk(q, 32'h0);
      end
      bus(1'b1, 8'h14, 32'hFFFF_FFFF, q);
      bus(1'b0, 8'h14, 32'h0000_0000, q);
      chk(q, 32'h7FF);
      bus(1'b1, 8'h0c, 32'hFFFF_FFFF, q);
      bus(1'b0, 8'h0c, 32'h0000_0000, q);
      chk(q, 32'h0);
      // dword requests: classes, partitions, translation types, filter tag
      run(0, 8'h83, 8'h01, 32'h0000_0701, 0, 3, rq(1'b0, 8'h01, 4'h1, 2'h0), 32'h3);
      run(1, 8'h83, 8'h02, 32'h0000_0704, 0, 3, rq(1'b0, 8'h02, 4'h4, 2'h0), 32'h3);
      run(0, 8'h83, 8'h02, 32'h0000_0701, 0, 3, rq(1'b1, 8'h02, 4'h1, 2'h0), 32'h0);
      run(0, 8'h83, 8'h08, 32'h0000_0702, 0, 3, rq(1'b1, 8'h08, 4'h2, 2'h0), 32'h0);
      run(0, 8'h83, 8'h04, 32'h0000_0710, 0, 4, rq(1'b0, 8'h04, 4'h2, 2'h1), 32'h4);
      run(1, 8'h83, 8'h40, 32'h0000_0720, 0, 2, rq(1'b0, 8'h40, 4'h8, 2'h2), 32'h2);
      run(0, 8'h83, 8'h01, 32'h0000_0704, 0, 3, rq(1'b0, 8'h01, 4'h1, 2'h0), 32'h0);
      run(0, 8'h83, 8'h01, 32'h0000_0001, 0, 3, rq(1'b0, 8'h01, 4'h1, 2'h0), 32'h0);
      run(0, 8'h83, 8'h04, 32'h0000_0701, 0, 3, rq(1'b0, 8'h01, 4'h1, 2'h0), 32'h0);
      run(2, 8'h83, 8'h01, 32'h0000_0701, 0, 3, rq(1'b0, 8'h01, 4'h1, 2'h0), 32'h0);
      // link, filter and null events
      run(0, 8'h0f, 8'h00, 32'h0000_0000, 1, 4, 16'h0000, 32'h4);
      run(0, 8'h0e, 8'h00, 32'h0000_0000, 2, 5, 16'h0000, 32'h5);
      run(1, 8'h0f, 8'h00, 32'h0000_0000, 2, 5, 16'h0000, 32'h0);
      run(0, 8'h21, 8'h00, 32'h0000_0000, 3, 2, 16'h0000, 32'h2);
      run(0, 8'h00, 8'h00, 32'h0000_0000, 1, 3, 16'h0000, 32'h0);
      run(3, 8'h00, 8'h00, 32'h0000_0000, 3, 3, 16'h0000, 32'h0);
      // debug bus matches: arg holds levels during, then idle levels
      run(3, 8'h02, 8'h03, 32'h0000_0000, 4, 3, 16'h0007, 32'h3);
      run(0, 8'h02, 8'h03, 32'h0000_0000, 4, 3, 16'h0001, 32'h0);
      run(2, 8'h02, 8'h04, 32'h0000_0000, 4, 3, 16'h000d, 32'h3);
      run(0, 8'h03, 8'h03, 32'h0000_0000, 4, 3, 16'h0001, 32'h3);
      run(0, 8'h03, 8'h20, 32'h0000_0000, 4, 3, 16'h000c, 32'h3);
      run(3, 8'h03, 8'h18, 32'h0000_0000, 4, 3, 16'h0006, 32'h3);
      // symbol time at the three speeds
      run(0, 8'h82, 8'h00, 32'h0000_0000, 5, 3, 16'h0000, 32'h3);
      run(0, 8'h82, 8'h00, 32'h0000_0000, 5, 3, 16'h0001, 32'h6);
      run(0, 8'h82, 8'h00, 32'h0000_0000, 5, 3, 16'h0002, 32'hc);
      // overflow raises status; interrupt masked, unmasked, cleared
      bus(1'b1, 8'h08, 32'hFFFF_FFFF, q);
      bus(1'b1, 8'h00, 32'h0040_000f, q);
      st.burst(1, 1, 16'h0000);
      bus(1'b1, 8'h00, 32'h0000_0000, q);
      bus(1'b0, 8'h40, 32'h0000_0000, q);
      chk(q, 32'h1);
      chk({31'h0000_0000, HRESP}, 32'h0);
      chk({31'h0000_0000, IRQ}, 32'h0);
      bus(1'b1, 8'h44, 32'h0000_0001, q);
      repeat (2) @(posedge SYS_CLK);
      chk({31'h0000_0000, IRQ}, 32'h1);
      bus(1'b1, 8'h40, 32'h0000_0001, q);
      repeat (2) @(posedge SYS_CLK);
      chk({31'h0000_0000, IRQ}, 32'h0);
      bus(1'b0, 8'h40, 32'h0000_0000, q);
      chk(q, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
